/* design/io_space_pkg.sv */
package io_space_pkg;

    // Request kinds issued by the processor core
    typedef enum logic [2:0] {
        KIND_IO_IN,
        KIND_IO_OUT,
        KIND_SET_BIT,
        KIND_CLEAR_BIT,
        KIND_SKIP_IF_SET,
        KIND_SKIP_IF_CLEAR,
        KIND_DATA_LOAD,
        KIND_DATA_STORE
    } req_kind_t;

    // Address windows
    localparam logic [7:0] IO_WINDOW_LAST = 8'h3F;
    localparam logic [7:0] BIT_RANGE_LAST = 8'h1F;
    localparam logic [7:0] DATA_IO_OFFSET = 8'h20;
    localparam logic [7:0] DATA_IO_LAST = 8'h5F;
    localparam logic [7:0] EXT_FIRST = 8'h60;
    localparam int UPPER_DEPTH = 32;
    localparam int LOWER_DEPTH = 32;

    // I/O addresses of the upper page
    localparam logic [5:0] IO_EEPROM_DATA = 6'h20;
    localparam logic [5:0] IO_EEPROM_ADDRESS_LOW = 6'h21;
    localparam logic [5:0] IO_EEPROM_ADDRESS_HIGH = 6'h22;
    localparam logic [5:0] IO_TIMER_GENERAL_CONTROL = 6'h23;
    localparam logic [5:0] IO_TIMER0_CONTROL_A = 6'h24;
    localparam logic [5:0] IO_TIMER0_CONTROL_B = 6'h25;
    localparam logic [5:0] IO_TIMER0_COUNT = 6'h26;
    localparam logic [5:0] IO_TIMER0_COMPARE_A = 6'h27;
    localparam logic [5:0] IO_TIMER0_COMPARE_B = 6'h28;
    localparam logic [5:0] IO_GENERAL_SCRATCH_1 = 6'h2A;
    localparam logic [5:0] IO_GENERAL_SCRATCH_2 = 6'h2B;
    localparam logic [5:0] IO_SERIAL_PORT_CONTROL = 6'h2C;
    localparam logic [5:0] IO_SERIAL_PORT_STATE = 6'h2D;
    localparam logic [5:0] IO_SERIAL_PORT_SHIFT_DATA = 6'h2E;
    localparam logic [5:0] IO_COMPARATOR_CONTROL_STATE = 6'h30;
    localparam logic [5:0] IO_SLEEP_CONTROL = 6'h33;
    localparam logic [5:0] IO_RESET_CAUSE_FLAGS = 6'h34;
    localparam logic [5:0] IO_CORE_CONTROL = 6'h35;
    localparam logic [5:0] IO_SELF_PROGRAM_CONTROL = 6'h37;
    localparam logic [5:0] IO_STACK_POINTER_LOW = 6'h3D;
    localparam logic [5:0] IO_STACK_POINTER_HIGH = 6'h3E;
    localparam logic [5:0] IO_CORE_FLAGS = 6'h3F;

    // Event flag register in the bit-addressable page
    localparam logic [4:0] LOW_FLAG_ADDR = 5'h16;

    // Serial port state fields
    localparam int SPS_DONE_BIT = 7;
    localparam int SPS_COLL_BIT = 6;
    localparam logic [7:0] SPS_RW_MASK = 8'h01;

    // Comparator control/state fields
    localparam int CMP_OUT_BIT = 5;
    localparam int CMP_FLAG_BIT = 4;
    localparam logic [7:0] CMP_RW_MASK = 8'hCF;

    // Reset value of every implemented register
    localparam logic [7:0] REG_RESET = 8'h00;

endpackage : io_space_pkg

/* design/flag_bits.sv */
`timescale 1ns/1ps
// Sticky event flags, cleared by writing one
module flag_bits #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Hardware events and software clears
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clear_i,
    // Flag state
    output logic [WIDTH-1:0] flags_o
);

    logic [WIDTH-1:0] flags_d; // Next flag state
    logic [WIDTH-1:0] flags_q; // Flag state

    // Set wins over a clear in the same cycle, so no event is lost
    always_comb begin
        flags_d = (flags_q & ~clear_i) | set_i;
    end

    // Flag storage
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;

    a_set_wins: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        (set_i != '0) |=> ((flags_q & $past(set_i)) == $past(set_i))) // R03
        else $error("flag event lost against a clear");

endmodule : flag_bits

/* design/io_space_address_decoder.sv */
`timescale 1ns/1ps
//
// Contract
// R01: Bit set/clear only on I/O 0x00-0x1F
// R02: Bit skip tests read low page bits
// R03: Selected flags clear on written one
// R04: Bit instructions touch only the addressed bit
// R05: Short I/O instructions reach addresses 0x00-0x3F
// R06: Data address equals I/O address plus 0x20
// R07: Extended 0x60-0xFF reachable by load/store only
// R08: Reserved locations read zero, ignore writes
module io_space_address_decoder (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Core request, one cycle per access
    input wire logic req_valid_i,
    input wire io_space_pkg::req_kind_t req_kind_i,
    input wire logic [7:0] req_addr_i,
    input wire logic [2:0] req_bit_i,
    input wire logic [7:0] req_wdata_i,
    // Answer, one cycle after the request
    output logic rsp_valid_o,
    output logic rsp_hit_o,
    output logic rsp_ext_o,
    output logic rsp_skip_o,
    output logic [7:0] rsp_rdata_o,
    // Peripheral events on the core clock
    input wire logic spi_done_i,
    input wire logic spi_collision_i,
    input wire logic cmp_event_i,
    input wire logic cmp_out_i,
    input wire logic [7:0] low_event_i,
    // Register views for the core
    output logic [7:0] core_flags_o,
    output logic [15:0] stack_pointer_o,
    output logic [7:0] sleep_control_o
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [7:0] upper_d [io_space_pkg::UPPER_DEPTH]; // Next upper page
    logic [7:0] upper_q [io_space_pkg::UPPER_DEPTH]; // Plain registers 0x20-0x3F
    logic [7:0] lower_d [io_space_pkg::LOWER_DEPTH]; // Next lower page
    logic [7:0] lower_q [io_space_pkg::LOWER_DEPTH]; // Bit-addressable page
    logic rsp_valid_d; // Next answer strobe
    logic rsp_valid_q;
    logic rsp_hit_d; // Next decode hit
    logic rsp_hit_q;
    logic rsp_ext_d; // Next extended-area marker
    logic rsp_ext_q;
    logic rsp_skip_d; // Next skip decision
    logic rsp_skip_q;
    logic [7:0] rsp_rdata_d; // Next read data
    logic [7:0] rsp_rdata_q;

    // Decode results
    logic [5:0] io_addr; // Resolved I/O address
    logic io_ok; // Access lands in the I/O window
    logic bit_ok; // Bit instruction lands in the low page
    logic ext_hit; // Data access to the extended area
    logic is_write; // Byte write
    logic is_read; // Byte read
    logic [7:0] bit_mask; // One-hot selected bit
    logic [7:0] rd_value; // Selected register value

    // Flag clear requests
    logic [7:0] low_flag_clr; // Clears for the event flag register
    logic [1:0] sps_flag_clr; // Clears for serial port flags
    logic cmp_flag_clr; // Clear for comparator flag
    logic [7:0] low_flags; // Event flag state
    logic [1:0] sps_flags; // Serial done, collision
    logic cmp_flag; // Comparator event

    ////////////////////////////////////////////////////////////////////////////
    // Sticky flags

    // Event flags in the bit-addressable page
    flag_bits #(.WIDTH(8)) u_low_flags (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .set_i(low_event_i),
        .clear_i(low_flag_clr),
        .flags_o(low_flags)
    );

    // Serial port completion and collision
    flag_bits #(.WIDTH(2)) u_sps_flags (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .set_i({spi_done_i, spi_collision_i}),
        .clear_i(sps_flag_clr),
        .flags_o(sps_flags)
    );

    // Comparator event
    flag_bits #(.WIDTH(1)) u_cmp_flag (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .set_i(cmp_event_i),
        .clear_i(cmp_flag_clr),
        .flags_o(cmp_flag)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    // Both instruction families resolve to one I/O address
    always_comb begin
        io_addr = req_addr_i[5:0];
        io_ok = 1'b0;
        bit_ok = 1'b0;
        ext_hit = 1'b0;
        is_write = 1'b0;
        is_read = 1'b0;
        bit_mask = 8'h01 << req_bit_i;
        if (req_valid_i) begin
            unique case (req_kind_i)
                io_space_pkg::KIND_IO_IN, io_space_pkg::KIND_IO_OUT: begin
                    // Opcode only encodes a 64-entry window
                    io_ok = (req_addr_i <= io_space_pkg::IO_WINDOW_LAST); // R05
                    is_read = io_ok && (req_kind_i == io_space_pkg::KIND_IO_IN);
                    is_write = io_ok && (req_kind_i == io_space_pkg::KIND_IO_OUT);
                end
                io_space_pkg::KIND_SET_BIT, io_space_pkg::KIND_CLEAR_BIT,
                io_space_pkg::KIND_SKIP_IF_SET, io_space_pkg::KIND_SKIP_IF_CLEAR: begin
                    // Anything above the low page is left alone
                    bit_ok = (req_addr_i <= io_space_pkg::BIT_RANGE_LAST); // R01
                    io_ok = bit_ok;
                end
                io_space_pkg::KIND_DATA_LOAD, io_space_pkg::KIND_DATA_STORE: begin
                    if (req_addr_i >= io_space_pkg::EXT_FIRST) begin
                        // Served outside this block
                        ext_hit = 1'b1; // R07
                    end else if (req_addr_i >= io_space_pkg::DATA_IO_OFFSET) begin
                        // Shift data address down onto the I/O map
                        io_addr = 6'(req_addr_i - io_space_pkg::DATA_IO_OFFSET); // R06
                        io_ok = 1'b1;
                        is_read = (req_kind_i == io_space_pkg::KIND_DATA_LOAD);
                        is_write = (req_kind_i == io_space_pkg::KIND_DATA_STORE);
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer

    // Reserved upper locations and unmapped space read as zero
    always_comb begin
        rd_value = 8'h00; // R08
        if (!io_addr[5]) begin
            if (io_addr[4:0] == io_space_pkg::LOW_FLAG_ADDR) begin
                rd_value = low_flags;
            end else begin
                rd_value = lower_q[io_addr[4:0]];
            end
        end else begin
            unique case (io_addr)
                io_space_pkg::IO_SERIAL_PORT_STATE: begin
                    rd_value = upper_q[io_addr[4:0]] & io_space_pkg::SPS_RW_MASK;
                    rd_value[io_space_pkg::SPS_DONE_BIT] = sps_flags[1];
                    rd_value[io_space_pkg::SPS_COLL_BIT] = sps_flags[0];
                end
                io_space_pkg::IO_COMPARATOR_CONTROL_STATE: begin
                    rd_value = upper_q[io_addr[4:0]] & io_space_pkg::CMP_RW_MASK;
                    rd_value[io_space_pkg::CMP_OUT_BIT] = cmp_out_i;
                    rd_value[io_space_pkg::CMP_FLAG_BIT] = cmp_flag;
                end
                io_space_pkg::IO_EEPROM_DATA, io_space_pkg::IO_EEPROM_ADDRESS_LOW,
                io_space_pkg::IO_EEPROM_ADDRESS_HIGH, io_space_pkg::IO_TIMER_GENERAL_CONTROL,
                io_space_pkg::IO_TIMER0_CONTROL_A, io_space_pkg::IO_TIMER0_CONTROL_B,
                io_space_pkg::IO_TIMER0_COUNT, io_space_pkg::IO_TIMER0_COMPARE_A,
                io_space_pkg::IO_TIMER0_COMPARE_B, io_space_pkg::IO_GENERAL_SCRATCH_1,
                io_space_pkg::IO_GENERAL_SCRATCH_2, io_space_pkg::IO_SERIAL_PORT_CONTROL,
                io_space_pkg::IO_SERIAL_PORT_SHIFT_DATA, io_space_pkg::IO_SLEEP_CONTROL,
                io_space_pkg::IO_RESET_CAUSE_FLAGS, io_space_pkg::IO_CORE_CONTROL,
                io_space_pkg::IO_SELF_PROGRAM_CONTROL, io_space_pkg::IO_STACK_POINTER_LOW,
                io_space_pkg::IO_STACK_POINTER_HIGH, io_space_pkg::IO_CORE_FLAGS: begin
                    rd_value = upper_q[io_addr[4:0]];
                end
                default: begin
                    rd_value = 8'h00; // R08
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register updates and answer

    // Next values for storage, flag clears and the answer
    always_comb begin
        upper_d = upper_q;
        lower_d = lower_q;
        low_flag_clr = 8'h00;
        sps_flag_clr = 2'b00;
        cmp_flag_clr = 1'b0;
        rsp_valid_d = req_valid_i;
        rsp_hit_d = io_ok; // R08
        rsp_ext_d = ext_hit; // R07
        rsp_skip_d = 1'b0;
        rsp_rdata_d = is_read ? rd_value : 8'h00;
        // Byte writes to the lower page
        if (is_write && !io_addr[5]) begin
            if (io_addr[4:0] == io_space_pkg::LOW_FLAG_ADDR) begin
                low_flag_clr = req_wdata_i; // R03
            end else begin
                lower_d[io_addr[4:0]] = req_wdata_i;
            end
        end
        // Byte writes to the upper page, reserved slots dropped
        if (is_write && io_addr[5]) begin
            unique case (io_addr)
                io_space_pkg::IO_SERIAL_PORT_STATE: begin
                    // Only the speed bit stores; flags clear on one
                    upper_d[io_addr[4:0]] = req_wdata_i & io_space_pkg::SPS_RW_MASK;
                    sps_flag_clr = {req_wdata_i[io_space_pkg::SPS_DONE_BIT],
                                    req_wdata_i[io_space_pkg::SPS_COLL_BIT]}; // R03
                end
                io_space_pkg::IO_COMPARATOR_CONTROL_STATE: begin
                    upper_d[io_addr[4:0]] = req_wdata_i & io_space_pkg::CMP_RW_MASK;
                    cmp_flag_clr = req_wdata_i[io_space_pkg::CMP_FLAG_BIT]; // R03
                end
                io_space_pkg::IO_EEPROM_DATA, io_space_pkg::IO_EEPROM_ADDRESS_LOW,
                io_space_pkg::IO_EEPROM_ADDRESS_HIGH, io_space_pkg::IO_TIMER_GENERAL_CONTROL,
                io_space_pkg::IO_TIMER0_CONTROL_A, io_space_pkg::IO_TIMER0_CONTROL_B,
                io_space_pkg::IO_TIMER0_COUNT, io_space_pkg::IO_TIMER0_COMPARE_A,
                io_space_pkg::IO_TIMER0_COMPARE_B, io_space_pkg::IO_GENERAL_SCRATCH_1,
                io_space_pkg::IO_GENERAL_SCRATCH_2, io_space_pkg::IO_SERIAL_PORT_CONTROL,
                io_space_pkg::IO_SERIAL_PORT_SHIFT_DATA, io_space_pkg::IO_SLEEP_CONTROL,
                io_space_pkg::IO_RESET_CAUSE_FLAGS, io_space_pkg::IO_CORE_CONTROL,
                io_space_pkg::IO_SELF_PROGRAM_CONTROL, io_space_pkg::IO_STACK_POINTER_LOW,
                io_space_pkg::IO_STACK_POINTER_HIGH, io_space_pkg::IO_CORE_FLAGS: begin
                    upper_d[io_addr[4:0]] = req_wdata_i;
                end
                default: begin
                    upper_d = upper_q; // R08
                end
            endcase
        end
        // Bit instructions in the low page
        if (bit_ok) begin
            unique case (req_kind_i)
                io_space_pkg::KIND_SET_BIT: begin
                    // Only the addressed bit is written, others see zero
                    if (io_addr[4:0] == io_space_pkg::LOW_FLAG_ADDR) begin
                        low_flag_clr = bit_mask; // R04
                    end else begin
                        lower_d[io_addr[4:0]] = lower_q[io_addr[4:0]] | bit_mask; // R01
                    end
                end
                io_space_pkg::KIND_CLEAR_BIT: begin
                    // Writing zero to a flag leaves it as it is
                    if (io_addr[4:0] != io_space_pkg::LOW_FLAG_ADDR) begin
                        lower_d[io_addr[4:0]] = lower_q[io_addr[4:0]] & ~bit_mask; // R04
                    end
                end
                io_space_pkg::KIND_SKIP_IF_SET: begin
                    rsp_skip_d = rd_value[req_bit_i]; // R02
                end
                io_space_pkg::KIND_SKIP_IF_CLEAR: begin
                    rsp_skip_d = !rd_value[req_bit_i]; // R02
                end
                default: begin
                    rsp_skip_d = 1'b0;
                end
            endcase
        end
    end

    // Register stage for all of the above
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < io_space_pkg::UPPER_DEPTH; i++) begin
                upper_q[i] <= io_space_pkg::REG_RESET;
            end
            for (int i = 0; i < io_space_pkg::LOWER_DEPTH; i++) begin
                lower_q[i] <= io_space_pkg::REG_RESET;
            end
            rsp_valid_q <= 1'b0;
            rsp_hit_q <= 1'b0;
            rsp_ext_q <= 1'b0;
            rsp_skip_q <= 1'b0;
            rsp_rdata_q <= 8'h00;
        end else begin
            upper_q <= upper_d;
            lower_q <= lower_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_hit_q <= rsp_hit_d;
            rsp_ext_q <= rsp_ext_d;
            rsp_skip_q <= rsp_skip_d;
            rsp_rdata_q <= rsp_rdata_d;
        end
    end

    // Outputs straight from flops
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_hit_o = rsp_hit_q;
    assign rsp_ext_o = rsp_ext_q;
    assign rsp_skip_o = rsp_skip_q;
    assign rsp_rdata_o = rsp_rdata_q;
    assign core_flags_o = upper_q[io_space_pkg::IO_CORE_FLAGS[4:0]];
    assign stack_pointer_o = {upper_q[io_space_pkg::IO_STACK_POINTER_HIGH[4:0]],
                              upper_q[io_space_pkg::IO_STACK_POINTER_LOW[4:0]]};
    assign sleep_control_o = upper_q[io_space_pkg::IO_SLEEP_CONTROL[4:0]];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    // Bit write aimed above the low page
    sequence s_high_bit_op;
        req_valid_i && (req_addr_i > io_space_pkg::BIT_RANGE_LAST) &&
        (req_kind_i inside {io_space_pkg::KIND_SET_BIT, io_space_pkg::KIND_CLEAR_BIT});
    endsequence

    // Load or store into the extended area
    sequence s_ext_access;
        req_valid_i && (req_addr_i >= io_space_pkg::EXT_FIRST) &&
        (req_kind_i inside {io_space_pkg::KIND_DATA_LOAD, io_space_pkg::KIND_DATA_STORE});
    endsequence

    a_high_bit_ignored: assert property (s_high_bit_op |=> // R01
        ($stable(core_flags_o) && $stable(stack_pointer_o) && $stable(sleep_control_o)))
        else $error("bit instruction changed an upper register");

    a_skip_decision: assert property (req_valid_i && // R02
        (req_kind_i == io_space_pkg::KIND_SKIP_IF_SET) && (req_addr_i[7:5] == 3'h0) &&
        (req_addr_i[4:0] != io_space_pkg::LOW_FLAG_ADDR)
        |=> rsp_skip_o == $past(lower_q[req_addr_i[4:0]][req_bit_i]))
        else $error("skip decision does not follow the tested bit");

    a_flag_zero_keeps: assert property (req_valid_i && // R03
        (req_kind_i == io_space_pkg::KIND_IO_OUT) &&
        (req_addr_i == {2'b00, io_space_pkg::IO_SERIAL_PORT_STATE}) &&
        !req_wdata_i[io_space_pkg::SPS_DONE_BIT] && sps_flags[1]
        |=> sps_flags[1])
        else $error("writing zero cleared a flag");

    a_flag_one_clears: assert property (req_valid_i && // R03
        (req_kind_i == io_space_pkg::KIND_IO_OUT) &&
        (req_addr_i == {2'b00, io_space_pkg::IO_SERIAL_PORT_STATE}) &&
        req_wdata_i[io_space_pkg::SPS_DONE_BIT] && !spi_done_i
        |=> !sps_flags[1])
        else $error("writing one left the flag set");

    a_bit_only_one: assert property (req_valid_i && // R04
        (req_kind_i == io_space_pkg::KIND_SET_BIT) &&
        (req_addr_i == {3'h0, io_space_pkg::LOW_FLAG_ADDR})
        |=> ((low_flags & ~$past(bit_mask)) ==
            (($past(low_flags) | $past(low_event_i)) & ~$past(bit_mask))))
        else $error("bit instruction disturbed other flags");

    a_io_window: assert property (req_valid_i && // R05
        (req_kind_i == io_space_pkg::KIND_IO_IN) && (req_addr_i > io_space_pkg::IO_WINDOW_LAST)
        |=> rsp_valid_o && !rsp_hit_o && (rsp_rdata_o == 8'h00))
        else $error("short I/O reached beyond its window");

    a_data_offset: assert property (req_valid_i && // R06
        (req_kind_i == io_space_pkg::KIND_DATA_LOAD) &&
        (req_addr_i == io_space_pkg::DATA_IO_LAST)
        |=> rsp_hit_o && (rsp_rdata_o == $past(core_flags_o)))
        else $error("load did not map onto the I/O register");

    a_ext_only: assert property (s_ext_access |=> rsp_ext_o && !rsp_hit_o) // R07
        else $error("extended access not flagged");

    a_reserved_zero: assert property (req_valid_i && // R08
        (req_kind_i == io_space_pkg::KIND_IO_IN) && (req_addr_i == 8'h3C)
        |=> rsp_hit_o && (rsp_rdata_o == 8'h00))
        else $error("reserved location did not read zero");

endmodule : io_space_address_decoder

/* verification/core_model.sv */
`timescale 1ns/1ps
// Core side of the decoder: one request at a time
module core_model (
    // Clock
    input wire logic clk_sys_i,
    // Request to the decoder
    output logic req_valid_o,
    output io_space_pkg::req_kind_t req_kind_o,
    output logic [7:0] req_addr_o,
    output logic [2:0] req_bit_o,
    output logic [7:0] req_wdata_o,
    // Answer strobe
    input wire logic rsp_valid_i
);
    // Idle state with junk qualifiers
    initial begin
        req_valid_o = 1'b0;
        req_kind_o = io_space_pkg::KIND_IO_IN;
        req_addr_o = 8'hA5;
        req_bit_o = 3'h0;
        req_wdata_o = 8'h5A;
    end
    // Drive on the falling edge, held across the taking edge
    task automatic issue(input io_space_pkg::req_kind_t k, input logic [7:0] a,
            input logic [2:0] b, input logic [7:0] d, output logic got);
        @(negedge clk_sys_i);
        req_valid_o = 1'b1;
        req_kind_o = k;
        req_addr_o = a;
        req_bit_o = b;
        req_wdata_o = d;
        @(negedge clk_sys_i);
        // Inverted leftovers, so stale values never pass for a request
        req_valid_o = 1'b0;
        req_addr_o = ~a;
        req_bit_o = ~b;
        req_wdata_o = ~d;
        got = rsp_valid_i;
        // Answer may land one edge later
        if (!got) begin
            @(negedge clk_sys_i);
            got = rsp_valid_i;
        end
    endtask : issue
endmodule : core_model

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic req_valid, rsp_valid, rsp_hit, rsp_ext, rsp_skip, ok;
    io_space_pkg::req_kind_t req_kind;
    logic [7:0] req_addr, req_wdata, rsp_rdata, core_flags, sleep_ctl, low_event = 8'h00;
    logic [7:0] rnd = 8'h5C; // Seed 92
    logic [7:0] a;
    logic [2:0] req_bit;
    logic [3:0] ev = 4'h0; // Serial done, collision, comparator event, comparator level
    logic [15:0] stack_ptr;
    logic [7:0] mem [0:63];
    int failures = 0;
    int n_tests = 0;
    // Plain storage bytes of the upper page
    localparam logic [7:0] UPPER [0:10] = '{8'h20, 8'h21, 8'h24, 8'h26, 8'h2A, 8'h2B,
        8'h2E, 8'h33, 8'h3D, 8'h3E, 8'h3F};

    // 8 ns clock
    always #4 clk_sys_i = ~clk_sys_i;

    core_model u_core (.clk_sys_i(clk_sys_i), .req_valid_o(req_valid), .req_kind_o(req_kind),
        .req_addr_o(req_addr), .req_bit_o(req_bit), .req_wdata_o(req_wdata),
        .rsp_valid_i(rsp_valid));
    io_space_address_decoder dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .req_valid_i(req_valid), .req_kind_i(req_kind), .req_addr_i(req_addr),
        .req_bit_i(req_bit), .req_wdata_i(req_wdata), .rsp_valid_o(rsp_valid),
        .rsp_hit_o(rsp_hit), .rsp_ext_o(rsp_ext), .rsp_skip_o(rsp_skip),
        .rsp_rdata_o(rsp_rdata), .spi_done_i(ev[3]), .spi_collision_i(ev[2]),
        .cmp_event_i(ev[1]), .cmp_out_i(ev[0]), .low_event_i(low_event),
        .core_flags_o(core_flags), .stack_pointer_o(stack_ptr), .sleep_control_o(sleep_ctl));

    // Pseudo-random byte stream
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t byte %h, expected %h", $time, got, exp);
        end
    endtask : check_byte
    task automatic check_bit(input logic got, input logic exp);
        check_byte({7'h00, got}, {7'h00, exp});
    endtask : check_bit
    // One access; the answer strobe must come
    task automatic acc(input io_space_pkg::req_kind_t k, input logic [7:0] ad,
            input logic [2:0] b, input logic [7:0] d);
        u_core.issue(k, ad, b, d, ok);
        check_bit(ok, 1'b1);
    endtask : acc
    task automatic finish_test;
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        #100000;
        failures++;
        finish_test();
    end

    initial begin
        for (int i = 0; i < 64; i++) mem[i] = 8'h00;
        repeat (12) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        acc(io_space_pkg::KIND_IO_IN, 8'h3F, 3'h0, 8'h00);
        check_byte(rsp_rdata, 8'h00);
        // Short and data-space writes, alternating in pairs, read back through data space
        for (int i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            a = i[0] ? UPPER[rnd % 11] : {3'h0, rnd[4:0]};
            if (a == 8'h16) a = 8'h00;
            rnd = lfsr(rnd);
            mem[a[5:0]] = rnd;
            acc(i[1] ? io_space_pkg::KIND_DATA_STORE : io_space_pkg::KIND_IO_OUT,
                i[1] ? a + 8'h20 : a, 3'h0, rnd);
            acc(io_space_pkg::KIND_DATA_LOAD, a + 8'h20, 3'h0, 8'h00);
            check_byte(rsp_rdata, mem[a[5:0]]);
        end
        check_byte(core_flags, mem[63]);
        check_byte(sleep_ctl, mem[51]);
        check_byte(stack_ptr[7:0], mem[61]);
        check_byte(stack_ptr[15:8], mem[62]);
        acc(io_space_pkg::KIND_DATA_LOAD, 8'h5F, 3'h0, 8'h00);
        check_byte(rsp_rdata, mem[63]);
        // Bit ops at the top of the low page
        for (int b = 0; b < 8; b++) begin
            rnd = lfsr(rnd);
            mem[31][b] = rnd[0];
            acc(rnd[0] ? io_space_pkg::KIND_SET_BIT : io_space_pkg::KIND_CLEAR_BIT, 8'h1F,
                b[2:0], 8'h00);
            acc(io_space_pkg::KIND_IO_IN, 8'h1F, 3'h0, 8'h00);
            check_byte(rsp_rdata, mem[31]);
            acc(io_space_pkg::KIND_SKIP_IF_SET, 8'h1F, b[2:0], 8'h00);
            check_bit(rsp_skip, rnd[0]);
            acc(io_space_pkg::KIND_SKIP_IF_CLEAR, 8'h1F, b[2:0], 8'h00);
            check_bit(rsp_skip, ~rnd[0]);
        end
        // Bit ops just above the low page do nothing
        acc(io_space_pkg::KIND_SET_BIT, 8'h20, 3'h7, 8'h00);
        check_bit(rsp_hit, 1'b0);
        acc(io_space_pkg::KIND_SKIP_IF_CLEAR, 8'h20, 3'h7, 8'h00);
        check_bit(rsp_skip, 1'b0);
        acc(io_space_pkg::KIND_IO_IN, 8'h20, 3'h0, 8'h00);
        check_byte(rsp_rdata, mem[32]);
        // Reserved slot keeps nothing
        acc(io_space_pkg::KIND_IO_OUT, 8'h3C, 3'h0, 8'hFF);
        acc(io_space_pkg::KIND_IO_IN, 8'h3C, 3'h0, 8'h00);
        check_byte({rsp_hit, rsp_rdata[6:0]}, 8'h80);
        // Extended area: data space only
        acc(io_space_pkg::KIND_DATA_LOAD, 8'h60, 3'h0, 8'h00);
        check_byte({rsp_ext, rsp_hit, rsp_rdata[5:0]}, 8'h80);
        acc(io_space_pkg::KIND_IO_IN, 8'h60, 3'h0, 8'h00);
        check_byte({rsp_ext, rsp_hit, 6'h00}, 8'h00);
        acc(io_space_pkg::KIND_DATA_LOAD, 8'h1F, 3'h0, 8'h00);
        check_bit(rsp_hit, 1'b0);
        // Sticky flags at 0x16: set bit clears one, zeros keep, ones clear
        low_event = 8'h24;
        @(negedge clk_sys_i);
        low_event = 8'h00;
        acc(io_space_pkg::KIND_SET_BIT, 8'h16, 3'h2, 8'h00);
        acc(io_space_pkg::KIND_IO_IN, 8'h16, 3'h0, 8'h00);
        check_byte(rsp_rdata, 8'h20);
        acc(io_space_pkg::KIND_IO_OUT, 8'h16, 3'h0, 8'h00);
        acc(io_space_pkg::KIND_IO_IN, 8'h16, 3'h0, 8'h00);
        check_byte(rsp_rdata, 8'h20);
        acc(io_space_pkg::KIND_IO_OUT, 8'h16, 3'h0, 8'h20);
        acc(io_space_pkg::KIND_IO_IN, 8'h16, 3'h0, 8'h00);
        check_byte(rsp_rdata, 8'h00);
        // Serial flags: zeros keep, ones clear; comparator flag: ones clear, live level reads through
        ev = 4'hF;
        @(negedge clk_sys_i);
        ev = 4'h1;
        acc(io_space_pkg::KIND_IO_OUT, 8'h2D, 3'h0, 8'h40);
        acc(io_space_pkg::KIND_IO_IN, 8'h2D, 3'h0, 8'h00);
        check_byte(rsp_rdata, 8'h80);
        acc(io_space_pkg::KIND_IO_OUT, 8'h2D, 3'h0, 8'h81);
        acc(io_space_pkg::KIND_IO_IN, 8'h2D, 3'h0, 8'h00);
        check_byte(rsp_rdata, 8'h01);
        acc(io_space_pkg::KIND_DATA_LOAD, 8'h50, 3'h0, 8'h00);
        check_byte(rsp_rdata, 8'h30);
        acc(io_space_pkg::KIND_DATA_STORE, 8'h50, 3'h0, 8'hFF);
        acc(io_space_pkg::KIND_IO_IN, 8'h30, 3'h0, 8'h00);
        check_byte(rsp_rdata, 8'hEF);
        finish_test();
    end
endmodule : tb
